/* verilog/scg_pkg.sv */
package scg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] OFF_RUN   = 12'h100;
  localparam logic [11:0] OFF_SLEEP = 12'h110;
  localparam logic [11:0] OFF_DEEP  = 12'h120;
  localparam logic [11:0] OFF_CFG   = 12'h130;
  localparam logic [11:0] OFF_STAT  = 12'h140;
  localparam logic [11:0] OFF_MASK  = 12'h144;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          NUM_UNITS   = 4;
  localparam int          U_CAN       = 0;
  localparam int          U_ADC       = 1;
  localparam int          U_WDOG      = 2;
  localparam int          U_HIBER     = 3;
  localparam int          UNIT_BIT [NUM_UNITS] = '{24, 16, 3, 6};
  localparam int          RATE_LO     = 8;
  localparam int          RATE_HI     = 9;
  localparam int          AUTO_BIT    = 0;
  localparam logic [31:0] GATE_RST    = 32'h0000_0040;
  localparam logic [31:0] GATE_WMASK  = 32'h0101_0348;
  localparam logic        CFG_RST     = 1'h0;
  localparam logic [1:0]  RATE_125K   = 2'h0;
  localparam logic [1:0]  RATE_250K   = 2'h1;
  localparam logic [1:0]  RATE_500K   = 2'h2;

  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} scg_mode_t;

endpackage : scg_pkg

/* verilog/scg_gate_if.sv */
`timescale 1ns/1ps
interface scg_gate_if;
  logic [31:0]                    run_word;
  logic [31:0]                    sleep_word;
  logic [31:0]                    deep_word;
  logic                           auto_sel;
  logic                           sleep;
  logic                           deep;
  logic [scg_pkg::NUM_UNITS-1:0]  gate;
  logic [1:0]                     rate;
  logic [scg_pkg::NUM_UNITS-1:0]  acc;
  logic [scg_pkg::NUM_UNITS-1:0]  fault;

  modport sel (input run_word, sleep_word, deep_word, auto_sel, sleep, deep, output gate, rate);
  modport chk (input gate, acc, output fault);
  modport top (output run_word, sleep_word, deep_word, auto_sel, sleep, deep, acc,
               input gate, rate, fault);
endinterface : scg_gate_if

/* verilog/scg_gate_sel.sv */
`timescale 1ns/1ps
module scg_gate_sel (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  scg_gate_if.sel   gif
);

  // ****************************************************************
  // Operating state and gating word selection
  // ****************************************************************
  scg_pkg::scg_mode_t             mode_reg;
  scg_pkg::scg_mode_t             mode_next;
  logic [31:0]                    act_word;
  logic [scg_pkg::NUM_UNITS-1:0]  gate_reg;
  logic [scg_pkg::NUM_UNITS-1:0]  gate_next;
  logic [1:0]                     rate_reg;

  assign mode_next = gif.deep ? scg_pkg::MODE_DEEP :
                     gif.sleep ? scg_pkg::MODE_SLEEP : scg_pkg::MODE_RUN;

  always_comb begin
    case (mode_reg)
      scg_pkg::MODE_SLEEP: act_word = gif.auto_sel ? gif.sleep_word : gif.run_word;
      scg_pkg::MODE_DEEP:  act_word = gif.auto_sel ? gif.deep_word : gif.run_word;
      default:             act_word = gif.run_word;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < scg_pkg::NUM_UNITS; gi++) begin : g_unit
      assign gate_next[gi] = act_word[scg_pkg::UNIT_BIT[gi]];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_reg <= scg_pkg::MODE_RUN;
      gate_reg <= '0;
      rate_reg <= scg_pkg::RATE_125K;
    end else begin
      mode_reg <= mode_next;
      gate_reg <= gate_next;
      rate_reg <= act_word[scg_pkg::RATE_HI:scg_pkg::RATE_LO];
    end
  end

  assign gif.gate = gate_reg;
  assign gif.rate = rate_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  run_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !gif.auto_sel && !$past(gif.auto_sel) |=>
      gif.gate[scg_pkg::U_WDOG] == $past(gif.run_word[3]))
    else $error("run gating not held without auto gating");

  deep_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    gif.auto_sel && gif.deep ##1 gif.auto_sel && gif.deep |=>
      gif.gate[scg_pkg::U_CAN] == $past(gif.deep_word[24]))
    else $error("deep sleep gating not applied");

  rate_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    mode_reg == scg_pkg::MODE_SLEEP && gif.auto_sel |=>
      gif.rate == $past(gif.sleep_word[9:8]))
    else $error("rate field not taken from sleep word");

endmodule : scg_gate_sel

/* verilog/scg_fault_chk.sv */
`timescale 1ns/1ps
module scg_fault_chk (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  scg_gate_if.chk   gif
);

  // ****************************************************************
  // Bus fault on access to an unclocked unit
  // ****************************************************************
  logic [scg_pkg::NUM_UNITS-1:0] fault_reg;
  logic [scg_pkg::NUM_UNITS-1:0] fault_next;

  genvar gi;
  generate
    for (gi = 0; gi < scg_pkg::NUM_UNITS; gi++) begin : g_unit
      assign fault_next[gi] = gif.acc[gi] & ~gif.gate[gi];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign gif.fault = fault_reg;

  fault_gen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    gif.acc[scg_pkg::U_ADC] && !gif.gate[scg_pkg::U_ADC] |=> gif.fault[scg_pkg::U_ADC])
    else $error("gated converter access did not fault");

  no_fault_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    gif.acc[scg_pkg::U_WDOG] && gif.gate[scg_pkg::U_WDOG] |=> !gif.fault[scg_pkg::U_WDOG])
    else $error("clocked watchdog access faulted");

endmodule : scg_fault_chk

/* verilog/scg_top.sv */
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Each writable gate bit except rate field 9:8 is a clock enable; set clocks the unit, clear stops it.
// - Access to an unclocked unit is answered with a bus fault.
// - Gate registers reset to 0x00000040; units start unclocked except noted.
// - Run register gates while running, sleep register in sleep, deep register in deep sleep.
// - Sleep and deep registers apply only with auto gating select set.
// - Bit 24 gates CAN, bit 16 gates converter; gated converter faults; both reset low.
// - Bit 6 gates hibernation and resets to one.
// - Bit 3 gates watchdog, resets low; access while unclocked faults.
// - Bits 9:8 pick converter rate: 0 125K, 1 250K, 2 500K samples/s.
// - Reserved bits are read-only zero; software preserves them on updates.
module scg_top (
  input  wire logic                           mclk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [11:0]                    paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  output logic      [31:0]                    prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  input  wire logic                           sleep_i,
  input  wire logic                           deep_sleep_i,
  input  wire logic [scg_pkg::NUM_UNITS-1:0]  unit_acc_i,
  output logic      [scg_pkg::NUM_UNITS-1:0]  unit_clk_en_o,
  output logic      [1:0]                     converter_rate_limit_o,
  output logic      [scg_pkg::NUM_UNITS-1:0]  unit_fault_o,
  output logic                                irq_o
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0]                    run_gate_reg0_reg;
  logic [31:0]                    sleep_gate_reg0_reg;
  logic [31:0]                    deep_sleep_gate_reg0_reg;
  logic                           auto_gating_select_reg;
  logic [scg_pkg::NUM_UNITS-1:0]  stat_reg;
  logic [scg_pkg::NUM_UNITS-1:0]  stat_next;
  logic [scg_pkg::NUM_UNITS-1:0]  mask_reg;
  logic                           irq_reg;
  logic [31:0]                    prdata_reg;
  logic                           pready_reg;
  logic                           pslverr_reg;

  scg_gate_if gif ();

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic        setup_w;
  logic        wr_w;
  logic        hit_run;
  logic        hit_sleep;
  logic        hit_deep;
  logic        hit_cfg;
  logic        hit_stat;
  logic        hit_mask;
  logic        hit_any;
  logic [31:0] rd_word;
  logic [31:0] wr_gate;
  logic [scg_pkg::NUM_UNITS-1:0] clr_w;

  assign setup_w   = psel_i & ~penable_i;
  assign wr_w      = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;
  assign hit_run   = paddr_i == scg_pkg::OFF_RUN;
  assign hit_sleep = paddr_i == scg_pkg::OFF_SLEEP;
  assign hit_deep  = paddr_i == scg_pkg::OFF_DEEP;
  assign hit_cfg   = paddr_i == scg_pkg::OFF_CFG;
  assign hit_stat  = paddr_i == scg_pkg::OFF_STAT;
  assign hit_mask  = paddr_i == scg_pkg::OFF_MASK;
  assign hit_any   = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
  assign wr_gate   = pwdata_i & scg_pkg::GATE_WMASK;

  assign rd_word = hit_run   ? run_gate_reg0_reg :
                   hit_sleep ? sleep_gate_reg0_reg :
                   hit_deep  ? deep_sleep_gate_reg0_reg :
                   hit_cfg   ? {31'h0000_0000, auto_gating_select_reg} :
                   hit_stat  ? {28'h000_0000, stat_reg} :
                   hit_mask  ? {28'h000_0000, mask_reg} : 32'h0000_0000;

  // ****************************************************************
  // APB answer
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_w;
      pslverr_reg <= setup_w & ~hit_any;
      if (setup_w) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ****************************************************************
  // Gating registers
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_gate_reg0_reg        <= scg_pkg::GATE_RST;
      sleep_gate_reg0_reg      <= scg_pkg::GATE_RST;
      deep_sleep_gate_reg0_reg <= scg_pkg::GATE_RST;
      auto_gating_select_reg   <= scg_pkg::CFG_RST;
    end else begin
      if (wr_w && hit_run) begin
        run_gate_reg0_reg <= wr_gate;
      end
      if (wr_w && hit_sleep) begin
        sleep_gate_reg0_reg <= wr_gate;
      end
      if (wr_w && hit_deep) begin
        deep_sleep_gate_reg0_reg <= wr_gate;
      end
      if (wr_w && hit_cfg) begin
        auto_gating_select_reg <= pwdata_i[scg_pkg::AUTO_BIT];
      end
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  assign clr_w     = (wr_w && hit_stat) ? pwdata_i[scg_pkg::NUM_UNITS-1:0] : '0;
  assign stat_next = (stat_reg & ~clr_w) | gif.fault;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      stat_reg <= '0;
      mask_reg <= '0;
      irq_reg  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      irq_reg  <= |(stat_reg & mask_reg);
      if (wr_w && hit_mask) begin
        mask_reg <= pwdata_i[scg_pkg::NUM_UNITS-1:0];
      end
    end
  end

  // ****************************************************************
  // Gate selection and fault check
  // ****************************************************************
  assign gif.run_word   = run_gate_reg0_reg;
  assign gif.sleep_word = sleep_gate_reg0_reg;
  assign gif.deep_word  = deep_sleep_gate_reg0_reg;
  assign gif.auto_sel   = auto_gating_select_reg;
  assign gif.sleep      = sleep_i;
  assign gif.deep       = deep_sleep_i;
  assign gif.acc        = unit_acc_i;

  scg_gate_sel u_sel (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .gif       (gif.sel)
  );

  scg_fault_chk u_chk (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .gif       (gif.chk)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata_o               = prdata_reg;
  assign pready_o               = pready_reg;
  assign pslverr_o              = pslverr_reg;
  assign unit_clk_en_o          = gif.gate;
  assign converter_rate_limit_o = gif.rate;
  assign unit_fault_o           = gif.fault;
  assign irq_o                  = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  reset_val_a: assert property (
    $past(sys_rst_i) |-> sleep_gate_reg0_reg == scg_pkg::GATE_RST
                         && run_gate_reg0_reg == scg_pkg::GATE_RST)
    else $error("gate register reset value wrong");

  sleep_wr_a: assert property (
    wr_w && hit_sleep |=> sleep_gate_reg0_reg == ($past(pwdata_i) & scg_pkg::GATE_WMASK))
    else $error("sleep gate write not stored");

  sleep_gate_a: assert property (
    wr_w && hit_sleep && auto_gating_select_reg && sleep_i && !deep_sleep_i
    ##1 sleep_i && !deep_sleep_i && auto_gating_select_reg |=>
      unit_clk_en_o[scg_pkg::U_HIBER] == $past(pwdata_i[6], 2))
    else $error("sleep gating not applied one edge after write");

  rsvd_zero_a: assert property (
    pready_reg && !pwrite_i && hit_sleep |-> (prdata_o & ~scg_pkg::GATE_WMASK) == 32'h0)
    else $error("reserved bits read nonzero");

  stat_set_a: assert property (
    gif.fault[scg_pkg::U_WDOG] |=> stat_reg[scg_pkg::U_WDOG])
    else $error("fault event lost against clear");

  irq_level_a: assert property (
    |(stat_reg & mask_reg) |=> irq_o)
    else $error("interrupt not raised");

  ready_one_a: assert property (
    setup_w |=> pready_o ##1 !pready_o)
    else $error("access phase not one cycle");

  unmapped_a: assert property (
    setup_w && !hit_any |=> pslverr_o)
    else $error("unmapped address not refused");

  sleep_wr_c:  cover property (wr_w && hit_sleep);
  sleep_use_c: cover property (auto_gating_select_reg && sleep_i ##2 unit_clk_en_o != '0);
  fault_c:     cover property (unit_fault_o[scg_pkg::U_ADC]);
  irq_c:       cover property ($rose(irq_o));

endmodule : scg_top

/* testbench/scg_unit_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Gated peripheral units seen from the clock gating block.
// ****************************************************************
module scg_unit_model (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [3:0]       clk_en_i,
  input  wire logic [3:0]       fault_i,
  input  wire logic [3:0]       req_i,
  output logic      [3:0]       acc_o,
  output logic      [3:0][7:0]  ticks_o,
  output logic      [7:0]       faults_o
);
  // Units try an access only when the bench commands one.
  assign acc_o = req_i;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ticks_o  <= '0;
      faults_o <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (clk_en_i[i]) ticks_o[i] <= ticks_o[i] + 8'h01;
      end
      faults_o <= faults_o + 8'($countones(fault_i));
    end
  end
endmodule : scg_unit_model

/* testbench/sleep_mode_clock_gating_reg0_bench.sv */
`timescale 1ns/1ps
module sleep_mode_clock_gating_reg0_bench;
  // ****************************************************************
  // Stimulus and instances
  // ****************************************************************
  logic             mclk    = 1'b0;
  logic             rst     = 1'b1;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [11:0]      paddr   = 12'h000;
  logic [31:0]      pwdata  = 32'h0000_0000;
  logic             sleep   = 1'b0;
  logic             deep    = 1'b0;
  logic [3:0]       req     = 4'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [3:0]       acc;
  logic [3:0]       en;
  logic [1:0]       rate;
  logic [3:0]       fault;
  logic             irq;
  logic [3:0][7:0]  ticks;
  logic [7:0]       faults;
  int               mismatches = 0;
  int               cmp_count  = 0;

  always #12.5 mclk = ~mclk;

  scg_top uut (.mclk_i(mclk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sleep_i(sleep), .deep_sleep_i(deep),
    .unit_acc_i(acc), .unit_clk_en_o(en), .converter_rate_limit_o(rate),
    .unit_fault_o(fault), .irq_o(irq));

  scg_unit_model partner (.mclk_i(mclk), .sys_rst_i(rst), .clk_en_i(en), .fault_i(fault),
    .req_i(req), .acc_o(acc), .ticks_o(ticks), .faults_o(faults));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb_wait", 32'(n), 32'h1);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk("wr_err", {31'h0, e}, {31'h0, xe});
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x,
                     input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
    chk("rd_err", {31'h0, e}, {31'h0, xe});
  endtask : rdc

  task automatic mode(input logic s, input logic d, input logic [3:0] xen,
                      input logic [1:0] xr);
    @(posedge mclk);
    sleep <= s;
    deep  <= d;
    wt(4);
    chk("clk_en", {28'h0, en}, {28'h0, xen});
    chk("rate", {30'h0, rate}, {30'h0, xr});
  endtask : mode

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    wt(3);
    chk("en_rst", {28'h0, en}, 32'h8);
    chk("rate_rst", {30'h0, rate}, 32'h0);
    rdc("run_rst", scg_pkg::OFF_RUN, 32'h0000_0040, 1'b0);
    rdc("sleep_rst", scg_pkg::OFF_SLEEP, 32'h0000_0040, 1'b0);
    rdc("deep_rst", scg_pkg::OFF_DEEP, 32'h0000_0040, 1'b0);
    rdc("cfg_rst", scg_pkg::OFF_CFG, 32'h0, 1'b0);
  endtask : t_reset

  task automatic t_regs;
    wr(scg_pkg::OFF_SLEEP, 32'hffff_ffff, 1'b0);
    rdc("sleep_ro", scg_pkg::OFF_SLEEP, 32'h0101_0348, 1'b0);
    wr(12'h104, 32'h0, 1'b1);
    rdc("unmapped", 12'h104, 32'h0, 1'b1);
    rdc("sleep_keep", scg_pkg::OFF_SLEEP, 32'h0101_0348, 1'b0);
    // Software enables what it needs and keeps the rate legal.
    wr(scg_pkg::OFF_RUN, 32'h0000_0008, 1'b0);
    wt(2);
    chk("en_upd", {28'h0, en}, 32'h4);
  endtask : t_regs

  task automatic t_select;
    logic [3:0][7:0] t0;
    wr(scg_pkg::OFF_RUN, 32'h0100_0100, 1'b0);
    wr(scg_pkg::OFF_SLEEP, 32'h0001_0248, 1'b0);
    wr(scg_pkg::OFF_DEEP, 32'h0000_0040, 1'b0);
    mode(1'b1, 1'b0, 4'b0001, 2'h1);
    wr(scg_pkg::OFF_CFG, 32'h1, 1'b0);
    mode(1'b1, 1'b0, 4'b1110, 2'h2);
    wr(scg_pkg::OFF_SLEEP, 32'h0000_0048, 1'b0);
    wt(2);
    chk("sleep_upd", {28'h0, en}, 32'hc);
    mode(1'b1, 1'b1, 4'b1000, 2'h0);
    mode(1'b0, 1'b0, 4'b0001, 2'h1);
    wr(scg_pkg::OFF_CFG, 32'h0, 1'b0);
    mode(1'b0, 1'b1, 4'b0001, 2'h1);
    mode(1'b0, 1'b0, 4'b0001, 2'h1);
    t0 = ticks;
    wt(4);
    chk("can_runs", {24'h0, ticks[0] - t0[0]}, 32'h4);
    chk("hib_stops", {24'h0, ticks[3] - t0[3]}, 32'h0);
  endtask : t_select

  task automatic t_fault;
    logic [7:0] f0;
    f0 = faults;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      req <= 4'(1 << i);
      @(posedge mclk);
      req <= 4'h0;
      wt(3);
      chk("faults", {24'h0, faults - f0}, 32'(i));
    end
    rdc("status", scg_pkg::OFF_STAT, 32'he, 1'b0);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(scg_pkg::OFF_MASK, 32'h4, 1'b0);
    wt(3);
    chk("irq_on", {31'h0, irq}, 32'h1);
    wr(scg_pkg::OFF_STAT, 32'h4, 1'b0);
    wt(3);
    chk("irq_off", {31'h0, irq}, 32'h0);
    rdc("status_w1c", scg_pkg::OFF_STAT, 32'ha, 1'b0);
  endtask : t_fault

  task automatic t_rerst;
    @(posedge mclk);
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(3);
    chk("en_rerst", {28'h0, en}, 32'h8);
    rdc("sleep_rerst", scg_pkg::OFF_SLEEP, 32'h0000_0040, 1'b0);
  endtask : t_rerst

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic conclude;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    wt(8);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_select;
    t_fault;
    t_rerst;
    conclude;
  end

  initial begin
    wt(20000);
    mismatches++;
    conclude;
  end
endmodule : sleep_mode_clock_gating_reg0_bench
